// File: src/wdt_pkg.sv
package wdt_pkg;

    // bus geometry
    localparam int WDT_AW = 12;
    localparam int WDT_DW = 32;

    // register indices; byte address is four times the index
    localparam logic [9:0] WDT_IDX_CTRL2 = 10'h0cc;   // second control register
    localparam logic [9:0] WDT_IDX_COUNT = 10'h0ce;   // watchdog down counter
    localparam logic [9:0] WDT_IDX_ENREG = 10'h0d0;   // reset-enable register
    localparam logic [WDT_AW-1:0] WDT_ADDR_CTRL2 = {WDT_IDX_CTRL2, 2'b00};
    localparam logic [WDT_AW-1:0] WDT_ADDR_COUNT = {WDT_IDX_COUNT, 2'b00};
    localparam logic [WDT_AW-1:0] WDT_ADDR_ENREG = {WDT_IDX_ENREG, 2'b00};

    // field positions
    localparam int WDT_ENREG_EN_BIT = 0;   // reset enable
    localparam int WDT_CTRL2_UDF_BIT = 0;  // underflow flag, read only

    // reset and load values
    localparam logic [7:0] WDT_LOAD_ALL_ONES = 8'hff;
    localparam logic [7:0] WDT_ZERO8 = 8'h00;

    // timing: oscillator divided by ten gives the instruction cycle
    localparam int WDT_TC_DIV = 10;
    localparam logic [3:0] WDT_TC_LAST = 4'(WDT_TC_DIV - 1);

    // ahb encodings
    localparam logic [1:0] WDT_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] WDT_HSIZE_WORD = 3'h2;

    // power state along halt, startup and run
    typedef enum logic [1:0] {
        WDT_ST_RUN = 2'b00,
        WDT_ST_HALT = 2'b01,
        WDT_ST_START = 2'b11
    } wdt_state_e;

    // latched address phase of an accepted transfer
    typedef struct packed {
        logic valid;
        logic write;
        logic [WDT_AW-1:0] addr;
    } wdt_aphase_s;

endpackage : wdt_pkg

// File: src/wdt_top.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module wdt_top
    import wdt_pkg::*;
(
    input wire logic sys_clk,                  // system clock, 125 MHz
    input wire logic rst,                      // async reset, power-up
    input wire logic hsel,                     // ahb slave select
    input wire logic [WDT_AW-1:0] haddr,       // ahb byte address
    input wire logic [1:0] htrans,             // ahb transfer type
    input wire logic hwrite,                   // ahb write
    input wire logic [2:0] hsize,              // ahb size
    input wire logic [WDT_DW-1:0] hwdata,      // ahb write data
    input wire logic hready,                   // ahb bus ready
    output logic [WDT_DW-1:0] hrdata,          // ahb read data
    output logic hreadyout,                    // ahb slave ready
    output logic hresp,                        // ahb response, always okay
    input wire logic ext_reset,                // external reset pin event
    input wire logic brownout_reset,           // brownout reset event
    input wire logic halt_enter,               // core enters halt
    input wire logic wakeup,                   // multi-input wakeup event
    input wire logic xtal_mode,                // two-pin crystal selected
    output logic wd_reset_req,                 // watchdog reset request
    output logic clk_hold,                     // core clocks held off
    output logic halted                        // core clocks stopped
);

    ////////////////////////////////////////////////////////////////////
    // state
    ////////////////////////////////////////////////////////////////////

    logic [3:0] tc_div;                        // oscillator divider
    logic tc_tick;                             // one instruction cycle
    logic [7:0] prescale;                      // prescaler
    logic [7:0] count;                         // watchdog down counter
    logic run_flag;                            // hidden start bit
    logic underflow_flag;                      // sticky underflow flag
    logic reset_enable;                        // reset enable bit
    logic enable_written;                      // write-once lock
    logic wd_reset_pend;                       // internal watchdog reset
    wdt_state_e state;                         // power state
    wdt_aphase_s aph;                          // pending data phase

    logic [7:0] next_prescale;
    logic [7:0] next_count;
    wdt_state_e next_state;

    ////////////////////////////////////////////////////////////////////
    // decode
    ////////////////////////////////////////////////////////////////////

    // address phase accepted
    wire a_take = hsel && htrans[1] && hready;
    // data phase writes, by target
    wire w_count = aph.valid && aph.write && (aph.addr == WDT_ADDR_COUNT);
    wire w_enreg = aph.valid && aph.write && (aph.addr == WDT_ADDR_ENREG);
    // external or brownout: reloads the counters and clears the flags and the enable lock
    wire hard_reset = ext_reset || brownout_reset;
    // any reset source, including the watchdog's own
    wire any_reset = hard_reset || wd_reset_pend;
    // prescaler and counter advance while running or timing startup
    wire advance = tc_tick && ((state == WDT_ST_RUN && run_flag) || state == WDT_ST_START);
    wire pre_term = (prescale == WDT_ZERO8);
    wire underflow = advance && (state == WDT_ST_RUN) && pre_term && (count == WDT_ZERO8);
    wire start_done = advance && (state == WDT_ST_START) && pre_term;

    // read mux, unmapped reads give zero
    function automatic logic [WDT_DW-1:0] rd_mux(input logic [WDT_AW-1:0] a);
        rd_mux = '0;
        if (a == WDT_ADDR_COUNT)
        begin
            rd_mux[7:0] = count;
        end
        else if (a == WDT_ADDR_ENREG)
        begin
            rd_mux[WDT_ENREG_EN_BIT] = reset_enable;
        end
        else if (a == WDT_ADDR_CTRL2)
        begin
            rd_mux[WDT_CTRL2_UDF_BIT] = underflow_flag;
        end
    endfunction : rd_mux

    ////////////////////////////////////////////////////////////////////
    // instruction cycle tick
    ////////////////////////////////////////////////////////////////////

    // divide by ten; ticks keep running so halt entry times cleanly
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tc_div <= 4'h0;
            tc_tick <= 1'b0;
        end
        else
        begin
            tc_div <= (tc_div == WDT_TC_LAST) ? 4'h0 : tc_div + 4'h1;
            tc_tick <= (tc_div == WDT_TC_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler and counter next values
    ////////////////////////////////////////////////////////////////////

    // priority: resets, halt entry, counter write, advance
    always_comb
    begin
        next_prescale = prescale;
        next_count = count;
        if (any_reset)
        begin
            next_prescale = WDT_LOAD_ALL_ONES;
            next_count = WDT_LOAD_ALL_ONES;
        end
        else if (halt_enter && state == WDT_ST_RUN)
        begin
            next_prescale = WDT_LOAD_ALL_ONES;
            next_count = WDT_LOAD_ALL_ONES;
        end
        else if (w_count)
        begin
            next_prescale = WDT_LOAD_ALL_ONES;
            next_count = hwdata[7:0];
        end
        else if (advance)
        begin
            next_prescale = prescale - 8'h01;
            if (pre_term)
            begin
                next_count = count - 8'h01;
            end
        end
    end

    // power state: halt, then startup delay on crystal wakeup
    always_comb
    begin
        next_state = state;
        case (state)
            WDT_ST_RUN:
            begin
                if (halt_enter && !any_reset)
                begin
                    next_state = WDT_ST_HALT;
                end
            end
            WDT_ST_HALT:
            begin
                // reset pin leaves halt at once; brownout and wakeup time xtal
                if (ext_reset || ((wakeup || brownout_reset) && !xtal_mode))
                begin
                    next_state = WDT_ST_RUN;
                end
                else if (wakeup || brownout_reset)
                begin
                    next_state = WDT_ST_START;
                end
            end
            WDT_ST_START:
            begin
                if (start_done)
                begin
                    next_state = WDT_ST_RUN;
                end
            end
            default:
            begin
                next_state = WDT_ST_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // counting registers
    ////////////////////////////////////////////////////////////////////

    // prescaler, counter and power state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prescale <= WDT_LOAD_ALL_ONES;
            count <= WDT_LOAD_ALL_ONES;
            state <= WDT_ST_RUN;
        end
        else
        begin
            prescale <= next_prescale;
            count <= next_count;
            state <= next_state;
        end
    end

    // run flag: write starts, underflow or any reset stops
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            run_flag <= 1'b0;
        end
        else if (any_reset)
        begin
            run_flag <= 1'b0;
        end
        else if (w_count)
        begin
            run_flag <= 1'b1;
        end
        else if (underflow)
        begin
            run_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status and control bits
    ////////////////////////////////////////////////////////////////////

    // underflow flag: set wins over a write or halt-entry clear in the same cycle; a hard reset wins over set
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            underflow_flag <= 1'b0;
        end
        else if (hard_reset)
        begin
            underflow_flag <= 1'b0;
        end
        else if (underflow)
        begin
            underflow_flag <= 1'b1;
        end
        else if (w_count || (halt_enter && state == WDT_ST_RUN))
        begin
            underflow_flag <= 1'b0;
        end
    end

    // reset enable: one write per hard reset, watchdog reset keeps it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reset_enable <= 1'b0;
            enable_written <= 1'b0;
        end
        else if (hard_reset)
        begin
            reset_enable <= 1'b0;
            enable_written <= 1'b0;
        end
        else if (w_enreg && !enable_written)
        begin
            reset_enable <= hwdata[WDT_ENREG_EN_BIT];
            enable_written <= 1'b1;
        end
    end

    // watchdog reset: internal one-shot plus request held one tc
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wd_reset_pend <= 1'b0;
            wd_reset_req <= 1'b0;
        end
        else
        begin
            wd_reset_pend <= underflow && reset_enable && !hard_reset;
            if (underflow && reset_enable)
            begin
                wd_reset_req <= 1'b1;
            end
            else if (tc_tick)
            begin
                wd_reset_req <= 1'b0;
            end
        end
    end

    // clock status seen by the core
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_hold <= 1'b0;
            halted <= 1'b0;
        end
        else
        begin
            clk_hold <= (next_state == WDT_ST_START);
            halted <= (next_state == WDT_ST_HALT);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave
    ////////////////////////////////////////////////////////////////////

    // zero wait states; read data captured in the address phase, so a
    // read right behind a write to the same register sees the old value
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aph <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            aph.valid <= a_take && (hsize == WDT_HSIZE_WORD);
            aph.write <= hwrite;
            aph.addr <= haddr;
            hrdata <= (a_take && !hwrite) ? rd_mux(haddr) : '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : wdt_top

// File: verif/wdt_monitor.sv
`timescale 1ns/1ps
module wdt_monitor
    import wdt_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst, // async reset
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic [WDT_DW-1:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic ext_reset, // external reset
    input wire logic brownout_reset, // brownout reset
    input wire logic halt_enter, // halt entry
    input wire logic wakeup, // wakeup
    input wire logic xtal_mode, // crystal mode
    input wire logic wd_reset_req, // reset request
    input wire logic clk_hold, // startup hold
    input wire logic halted // halted
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // accepted read and quiet power inputs
    wire rd_acc = hsel && htrans[1] && !hwrite && hready;
    wire no_rst = !ext_reset && !brownout_reset;
    // startup hold bounds: the tick phase moves the first tick by up to ten clocks
    localparam logic [11:0] HOLD_MIN = 12'(255 * WDT_TC_DIV + 1);
    localparam logic [11:0] HOLD_MAX = 12'(256 * WDT_TC_DIV);
    // clocks the startup hold has stood so far; a counter is used because
    // the hold is far too long for a repetition or a delay range
    logic [11:0] hold_cnt;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hold_cnt <= 12'h000;
        end
        else
        begin
            hold_cnt <= clk_hold ? hold_cnt + 12'h001 : 12'h000;
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_ready_high: assert property (hreadyout) else $error("ready dropped");
    chk_resp_okay: assert property (!hresp) else $error("response not okay");
    chk_rdata_idle: assert property (!rd_acc |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_rdata_upper: assert property (rd_acc |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // a request lasts one instruction cycle of ten clocks
    chk_req_width: assert property ($rose(wd_reset_req) |-> wd_reset_req[*8] ##[1:3] !wd_reset_req)
        else $error("request width wrong");
    chk_halt_entry: assert property (halt_enter && !halted && !clk_hold && no_rst |=> halted)
        else $error("halt not entered");
    chk_wake_plain: assert property (halted && wakeup && !xtal_mode && no_rst |=> !halted && !clk_hold)
        else $error("plain wakeup failed");
    chk_wake_xtal: assert property (halted && wakeup && xtal_mode && no_rst |=> clk_hold)
        else $error("crystal wakeup without hold");
    // 256 ticks of ten clocks, give or take the tick phase
    chk_hold_len: assert property ($fell(clk_hold) |-> hold_cnt >= HOLD_MIN && hold_cnt <= HOLD_MAX)
        else $error("startup hold length wrong");
    chk_hold_max: assert property (clk_hold |-> hold_cnt < HOLD_MAX)
        else $error("startup hold too long");
    cov_req: cover property ($rose(wd_reset_req));
    cov_hold: cover property ($rose(clk_hold));
    cov_halt: cover property ($rose(halted));
endmodule : wdt_monitor

bind wdt_top wdt_monitor u_mon (
    .sys_clk(sys_clk),
    .rst(rst),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ext_reset(ext_reset),
    .brownout_reset(brownout_reset),
    .halt_enter(halt_enter),
    .wakeup(wakeup),
    .xtal_mode(xtal_mode),
    .wd_reset_req(wd_reset_req),
    .clk_hold(clk_hold),
    .halted(halted)
);

// File: verif/supervisory_watchdog_timer_bench.sv
`timescale 1ns/1ps
module supervisory_watchdog_timer_bench
    import wdt_pkg::*;
;
    logic sys_clk, rst, hsel, hwrite, ext_reset, brownout_reset, halt_enter, wakeup, xtal_mode;
    logic [WDT_AW-1:0] haddr; // bus address
    logic [1:0] htrans; // transfer type
    logic [2:0] hsize; // transfer size
    logic [WDT_DW-1:0] hwdata, hrdata, rd, d; // bus data
    logic hreadyout, hresp, wd_reset_req, clk_hold, halted, req_seen;
    logic [7:0] v; // random count
    int fails, n_checks, seed, i, w;
    time t0; // start of a timed load

    // one slave, so its ready is the bus ready
    wdt_top u_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .ext_reset(ext_reset),
        .brownout_reset(brownout_reset),
        .halt_enter(halt_enter),
        .wakeup(wakeup),
        .xtal_mode(xtal_mode),
        .wd_reset_req(wd_reset_req),
        .clk_hold(clk_hold),
        .halted(halted)
    );

    ////////////////////////////////////////////////////////////////
    // clock and request watcher
    initial
    begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (wd_reset_req === 1'b1) req_seen <= 1'b1;

    function logic [31:0] exp_word(input logic [7:0] x);
        return {24'h0, x}; // registers sit in the low byte
    endfunction : exp_word

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // single word transfer; read data lands in rd
    task bus(input logic wr, input logic [WDT_AW-1:0] a, input logic [31:0] dat);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= WDT_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= WDT_HSIZE_WORD;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task print_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // hang guard, 40000 clocks, well above three one-period spans of 2560 clocks
    initial
    begin
        #(8 * 40000);
        fails++;
        print_verdict;
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h2bf900ec;
        {fails, n_checks, req_seen, hsel, hwrite, haddr, htrans, hsize, hwdata} = 0;
        {ext_reset, brownout_reset, halt_enter, wakeup, xtal_mode} = 5'h0;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        bus(0, WDT_ADDR_COUNT, 0); check("count_rst", rd, exp_word(8'hff));
        bus(0, WDT_ADDR_ENREG, 0); check("enable_rst", rd, 32'h0);
        bus(0, 12'h004, 0); check("unmapped", rd, 32'h0);
        bus(1, WDT_ADDR_CTRL2, 32'h1);
        bus(0, WDT_ADDR_CTRL2, 0); check("flag_ro", rd, 32'h0);
        // random counts with junk in the upper bits
        for (i = 0; i < 4; i++)
        begin
            d = $random(seed);
            v = d[7:0];
            bus(1, WDT_ADDR_COUNT, d);
            bus(0, WDT_ADDR_COUNT, 0); check("count_rw", rd, exp_word(v));
        end
        // timer mode: load zero, i.e. one period, poll the flag
        bus(1, WDT_ADDR_COUNT, 32'h0);
        t0 = $time;
        i = 0;
        do
        begin
            bus(0, WDT_ADDR_CTRL2, 0);
            i++;
        end
        while (rd[0] !== 1'b1 && i < 2000);
        check("timer_flag", rd, 32'h1);
        // one period is 256 ticks of ten clocks, plus a few clocks of poll lag
        w = int'(($time - t0) / 8);
        check("period", (w >= 2550 && w <= 2570), 32'h1);
        check("no_request", req_seen, 32'h0);
        repeat (40) @(posedge sys_clk);
        bus(0, WDT_ADDR_COUNT, 0); check("count_stop", rd, exp_word(8'hff));
        // enable once, then a refused clear
        bus(1, WDT_ADDR_ENREG, 32'h1);
        bus(1, WDT_ADDR_ENREG, 32'h0);
        bus(0, WDT_ADDR_ENREG, 0); check("enable_once", rd, 32'h1);
        bus(1, WDT_ADDR_COUNT, 32'h0);
        bus(0, WDT_ADDR_CTRL2, 0); check("flag_wr_clr", rd, 32'h0);
        i = 0;
        while (wd_reset_req !== 1'b1 && i < 3000)
        begin
            @(posedge sys_clk);
            i++;
        end
        w = 0;
        while (wd_reset_req === 1'b1 && w < 20)
        begin
            @(posedge sys_clk);
            w++;
        end
        check("req_width", (w >= 9 && w <= 10), 32'h1);
        bus(0, WDT_ADDR_ENREG, 0); check("enable_kept", rd, 32'h1);
        bus(0, WDT_ADDR_CTRL2, 0); check("flag_kept", rd, 32'h1);
        bus(0, WDT_ADDR_COUNT, 0); check("count_wdrst", rd, exp_word(8'hff));
        // halt with the flag set, plain wakeup
        @(posedge sys_clk);
        halt_enter <= 1'b1;
        @(posedge sys_clk);
        halt_enter <= 1'b0;
        @(posedge sys_clk);
        check("halted", halted, 32'h1);
        wakeup <= 1'b1;
        @(posedge sys_clk);
        wakeup <= 1'b0;
        bus(0, WDT_ADDR_CTRL2, 0); check("flag_halt", rd, 32'h0);
        bus(0, WDT_ADDR_COUNT, 0); check("count_halt", rd, exp_word(8'hff));
        // halt again, crystal wakeup runs the startup delay
        @(posedge sys_clk);
        xtal_mode <= 1'b1;
        halt_enter <= 1'b1;
        @(posedge sys_clk);
        halt_enter <= 1'b0;
        @(posedge sys_clk);
        wakeup <= 1'b1;
        @(posedge sys_clk);
        wakeup <= 1'b0;
        @(posedge sys_clk);
        check("hold", clk_hold, 32'h1);
        i = 0;
        while (clk_hold === 1'b1 && i < 3000)
        begin
            @(posedge sys_clk);
            i++;
        end
        check("hold_len", (i > 2500 && i < 2600), 32'h1);
        bus(0, WDT_ADDR_COUNT, 0); check("count_start", rd, exp_word(8'hfe));
        // external reset clears enable and reopens the single write
        @(posedge sys_clk);
        ext_reset <= 1'b1;
        @(posedge sys_clk);
        ext_reset <= 1'b0;
        bus(0, WDT_ADDR_ENREG, 0); check("enable_ext", rd, 32'h0);
        bus(0, WDT_ADDR_COUNT, 0); check("count_ext", rd, exp_word(8'hff));
        bus(1, WDT_ADDR_ENREG, 32'h0);
        bus(1, WDT_ADDR_ENREG, 32'h1);
        bus(0, WDT_ADDR_ENREG, 0); check("enable_lock", rd, 32'h0);
        @(posedge sys_clk);
        brownout_reset <= 1'b1;
        @(posedge sys_clk);
        brownout_reset <= 1'b0;
        bus(1, WDT_ADDR_ENREG, 32'h1);
        bus(0, WDT_ADDR_ENREG, 0); check("enable_bor", rd, 32'h1);
        print_verdict;
    end
endmodule : supervisory_watchdog_timer_bench
